// >>> rt_command_illegalization.sv
// command legality checker: table clear, lookup and verdict, APB registers
//
// Operation
// - all-zero table: every valid command answered in form, clear status, except broadcast transmit subaddress and silenced undefined modes
// - table bit one: status only, message error set, no data words
// - table bit zero: clear status and full data word count
// - after reset, clear the whole table, then raise ready
// - with execution started, one table bit fetched per valid command accepted in idle, none for silent commands
// - table spans word addresses 0x0200 to 0x02FF, 256 words
// - subaddress even word: bit n is count n, bit 0 is 32
// - subaddress odd word: bit 0 is count 16 up to bit 15 is 31
// - mode commands: even word codes 0-15, odd word codes 16-31
// - broadcast transmit subaddress commands: invalid, no answer at all
// - address from direction, subaddress, count MSB and broadcast
// - broadcast and direction each select their own table entries
// - transmit subaddress 1 checked at words TX_SA1_LO_IDX and TX_SA1_HI_IDX, 0x02C2 and 0x02C3
// - legality resolved separately for the 4096 combinations, except broadcast transmit subaddress ones, always silent
// - undefined mode invalid bit set: undefined modes silent, no lookup
`timescale 1ns/10ps
module rt_command_illegalization (
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      cmdValid,
  input  wire rt_illegal_pkg::cmd_t      cmdIn,
  output logic                           cmdBusy,
  output logic                           verdictValid,
  output rt_illegal_pkg::verdict_t       verdict,
  output logic                           hostReady
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  rt_illegal_pkg::lk_state_t state_ff;
  rt_illegal_pkg::lk_state_t nxt_state;
  rt_illegal_pkg::cmd_t      cmdQ_ff;
  rt_illegal_pkg::cmd_t      nxt_cmdQ;
  rt_illegal_pkg::verdict_t  verdict_ff;
  rt_illegal_pkg::verdict_t  nxt_verdict;
  logic                      verdictValid_ff;
  logic                      nxt_verdictValid;
  logic [7:0]                clrIdx_ff;
  logic [7:0]                nxt_clrIdx;
  logic                      ready_ff;
  logic                      nxt_ready;
  logic                      silentQ_ff;
  logic                      nxt_silentQ;
  logic [7:0]                lastIdx_ff;
  logic [7:0]                nxt_lastIdx;
  logic                      execStart_ff;
  logic                      nxt_execStart;
  logic                      undefined_mode_invalid_ff;
  logic                      nxt_undefined_mode_invalid;

  logic        accept;
  logic        silentNow;
  logic        illegalBit;
  logic [9:0]  regIdx;
  logic        hitTable;
  logic        hitCfg;
  logic        hitStatus;
  logic        apbDone;
  logic        tblWrEn;
  logic [7:0]  tblWrAddr;
  logic [15:0] tblWrData;
  logic [15:0] tblDataA;
  logic [15:0] tblDataB;

  ////////////////////////////////////////////////////////////////////////////
  // table storage

  cmd_illegal_table u_table (
    .sys_clk (sys_clk),
    .wrEn    (tblWrEn),
    .wrAddr  (tblWrAddr),
    .wrData  (tblWrData),
    .rdEnA   (accept && !silentNow),
    .rdAddrA (rt_illegal_pkg::tableIndex(cmdIn)),
    .rdDataA (tblDataA),
    .rdAddrB (paddr[9:2]),
    .rdDataB (tblDataB)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  assign regIdx    = paddr[11:2];
  assign hitTable  = (regIdx >= rt_illegal_pkg::TABLE_BASE) &&
                     (regIdx <= rt_illegal_pkg::TABLE_LAST);
  assign hitCfg    = regIdx == rt_illegal_pkg::CFG_IDX;
  assign hitStatus = regIdx == rt_illegal_pkg::STATUS_IDX;
  assign apbDone   = psel && penable && ready_ff;

  // accesses wait while the table is being cleared
  assign pready  = ready_ff;
  assign pslverr = psel && penable && !(hitTable || hitCfg ||
                   (hitStatus && !pwrite));

  // clearing owns the write port until ready
  always_comb begin
    if (state_ff == rt_illegal_pkg::ST_CLEAR) begin
      tblWrEn   = 1'b1;
      tblWrAddr = clrIdx_ff;
      tblWrData = 16'h0000;
    end else begin
      tblWrEn   = apbDone && pwrite && hitTable;
      tblWrAddr = paddr[9:2];
      tblWrData = pwdata[15:0];
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (hitTable) begin
      prdata[15:0] = tblDataB;
    end else if (hitCfg) begin
      prdata[rt_illegal_pkg::CFG_EXEC_BIT]   = execStart_ff;
      prdata[rt_illegal_pkg::CFG_UNDEF_BIT]  = undefined_mode_invalid_ff;
    end else if (hitStatus) begin
      prdata[rt_illegal_pkg::ST_READY_BIT] = ready_ff;
      prdata[rt_illegal_pkg::ST_BUSY_BIT]  = cmdBusy;
      prdata[rt_illegal_pkg::ST_RESP_BIT]  = verdict_ff.respond;
      prdata[rt_illegal_pkg::ST_MERR_BIT]  = verdict_ff.msgError;
      prdata[rt_illegal_pkg::ST_IDX_LO +: 8] = lastIdx_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration register

  always_comb begin
    nxt_execStart = execStart_ff;
    nxt_undefined_mode_invalid    = undefined_mode_invalid_ff;
    if (apbDone && pwrite && hitCfg) begin
      nxt_execStart = pwdata[rt_illegal_pkg::CFG_EXEC_BIT];
      nxt_undefined_mode_invalid    = pwdata[rt_illegal_pkg::CFG_UNDEF_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      execStart_ff <= rt_illegal_pkg::CFG_RESET[rt_illegal_pkg::CFG_EXEC_BIT];
      undefined_mode_invalid_ff    <= rt_illegal_pkg::CFG_RESET[rt_illegal_pkg::CFG_UNDEF_BIT];
    end else begin
      execStart_ff <= nxt_execStart;
      undefined_mode_invalid_ff    <= nxt_undefined_mode_invalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clear, lookup and verdict

  assign accept = cmdValid && execStart_ff &&
                  (state_ff == rt_illegal_pkg::ST_IDLE);
  assign silentNow = rt_illegal_pkg::isBcastTxSub(cmdIn) ||
                     (undefined_mode_invalid_ff &&
                      rt_illegal_pkg::isUndefinedMode(cmdIn));
  // low count bits pick the bit in either word of the pair
  assign illegalBit = tblDataA[cmdQ_ff.word[3:0]];

  always_comb begin
    nxt_state        = state_ff;
    nxt_clrIdx       = clrIdx_ff;
    nxt_ready        = ready_ff;
    nxt_cmdQ         = cmdQ_ff;
    nxt_silentQ      = silentQ_ff;
    nxt_lastIdx      = lastIdx_ff;
    nxt_verdict      = verdict_ff;
    nxt_verdictValid = 1'b0;
    case (state_ff)
      rt_illegal_pkg::ST_CLEAR: begin
        nxt_clrIdx = clrIdx_ff + 8'h01;
        if (clrIdx_ff == rt_illegal_pkg::CLEAR_LAST) begin
          nxt_ready = 1'b1;
          nxt_state = rt_illegal_pkg::ST_IDLE;
        end
      end
      rt_illegal_pkg::ST_IDLE: begin
        if (accept) begin
          nxt_cmdQ    = cmdIn;
          nxt_silentQ = silentNow;
          nxt_lastIdx = rt_illegal_pkg::tableIndex(cmdIn);
          nxt_state   = rt_illegal_pkg::ST_FETCH;
        end
      end
      rt_illegal_pkg::ST_FETCH: begin
        nxt_verdictValid = 1'b1;
        nxt_state        = rt_illegal_pkg::ST_IDLE;
        if (silentQ_ff) begin
          nxt_verdict = '{respond: 1'b0, msgError: 1'b0,
                          dataWords: 6'h00};
        end else if (illegalBit) begin
          nxt_verdict = '{respond: 1'b1, msgError: 1'b1,
                          dataWords: 6'h00};
        end else begin
          nxt_verdict = '{respond: 1'b1, msgError: 1'b0,
                          dataWords: rt_illegal_pkg::inFormWords(cmdQ_ff)};
        end
      end
      default: begin
        nxt_state = rt_illegal_pkg::ST_CLEAR;
        nxt_clrIdx = 8'h00;
        nxt_ready  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff        <= rt_illegal_pkg::ST_CLEAR;
      clrIdx_ff       <= 8'h00;
      ready_ff        <= 1'b0;
      cmdQ_ff         <= '0;
      silentQ_ff      <= 1'b0;
      lastIdx_ff      <= 8'h00;
      verdict_ff      <= '0;
      verdictValid_ff <= 1'b0;
    end else begin
      state_ff        <= nxt_state;
      clrIdx_ff       <= nxt_clrIdx;
      ready_ff        <= nxt_ready;
      cmdQ_ff         <= nxt_cmdQ;
      silentQ_ff      <= nxt_silentQ;
      lastIdx_ff      <= nxt_lastIdx;
      verdict_ff      <= nxt_verdict;
      verdictValid_ff <= nxt_verdictValid;
    end
  end

  assign cmdBusy      = state_ff != rt_illegal_pkg::ST_IDLE;
  assign verdictValid = verdictValid_ff;
  assign verdict      = verdict_ff;
  assign hostReady    = ready_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  a_ready_after_clear: assert property (
    $rose(ready_ff) |->
      $past(clrIdx_ff) == rt_illegal_pkg::CLEAR_LAST &&
      $past(state_ff) == rt_illegal_pkg::ST_CLEAR)
    else $error("ready rose before the table clear finished");

  a_one_fetch_per_cmd: assert property (
    accept |=> state_ff == rt_illegal_pkg::ST_FETCH ##1
      (verdictValid_ff && state_ff == rt_illegal_pkg::ST_IDLE) ##1
      !verdictValid_ff)
    else $error("accepted command did not give exactly one verdict");

  a_idle_when_stopped: assert property (
    (state_ff == rt_illegal_pkg::ST_IDLE && !execStart_ff) |=>
      state_ff != rt_illegal_pkg::ST_FETCH)
    else $error("lookup started without execution start");

  a_legal_in_form: assert property (
    (state_ff == rt_illegal_pkg::ST_FETCH && !silentQ_ff &&
     !tblDataA[cmdQ_ff.word[3:0]]) |=>
      verdict_ff.respond && !verdict_ff.msgError &&
      verdict_ff.dataWords == rt_illegal_pkg::inFormWords($past(cmdQ_ff)))
    else $error("legal command not answered in form");

  a_illegal_status_only: assert property (
    (state_ff == rt_illegal_pkg::ST_FETCH && !silentQ_ff &&
     tblDataA[cmdQ_ff.word[3:0]]) |=>
      verdict_ff.respond && verdict_ff.msgError &&
      verdict_ff.dataWords == 6'h00)
    else $error("illegal command not answered with message error only");

  a_bcast_tx_silent: assert property (
    (accept && rt_illegal_pkg::isBcastTxSub(cmdIn)) |-> ##2
      (verdictValid_ff && !verdict_ff.respond))
    else $error("broadcast transmit subaddress command was answered");

  a_undef_mode_silent: assert property (
    (accept && undefined_mode_invalid_ff && rt_illegal_pkg::isUndefinedMode(cmdIn)) |->
      ##2 (verdictValid_ff && !verdict_ff.respond && !verdict_ff.msgError))
    else $error("undefined mode command answered while marked invalid");

  a_tx_sa1_words: assert property (
    (accept && !cmdIn.broadcast && cmdIn.word[rt_illegal_pkg::TR_BIT] &&
     cmdIn.word[rt_illegal_pkg::SA_HI:rt_illegal_pkg::SA_LO] == 5'h01) |=>
      {2'b10, lastIdx_ff} ==
        (cmdQ_ff.word[rt_illegal_pkg::WC_HI] ?
         rt_illegal_pkg::TX_SA1_HI_IDX : rt_illegal_pkg::TX_SA1_LO_IDX))
    else $error("transmit subaddress 1 used the wrong table word");

  a_count32_bit0: assert property (
    (state_ff == rt_illegal_pkg::ST_FETCH && !silentQ_ff &&
     !rt_illegal_pkg::isMode(cmdQ_ff) && cmdQ_ff.word[4:0] == 5'h00) |=>
      verdict_ff.msgError == $past(tblDataA[0]) &&
      (verdict_ff.msgError || verdict_ff.dataWords == 6'h20))
    else $error("count 32 not checked against bit 0");

endmodule

// >>> rt_illegal_pkg.sv
// constants, types and decode functions for the command legality checker
package rt_illegal_pkg;

  // shared table, word addresses
  localparam logic [9:0] TABLE_BASE    = 10'h200;
  localparam int         TABLE_WORDS   = 256;
  localparam logic [9:0] TABLE_LAST    = 10'h2FF;
  localparam logic [9:0] TX_SA1_LO_IDX = 10'h2C2;
  localparam logic [9:0] TX_SA1_HI_IDX = 10'h2C3;
  localparam logic [7:0] CLEAR_LAST    = 8'hFF;

  // own registers, word index (byte address = 4 * index)
  localparam logic [9:0] CFG_IDX    = 10'h000;
  localparam logic [9:0] STATUS_IDX = 10'h001;

  // config fields
  localparam int CFG_EXEC_BIT  = 0;
  localparam int CFG_UNDEF_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;

  // status fields
  localparam int ST_READY_BIT = 0;
  localparam int ST_BUSY_BIT  = 1;
  localparam int ST_RESP_BIT  = 2;
  localparam int ST_MERR_BIT  = 3;
  localparam int ST_IDX_LO    = 8;

  // command word fields
  localparam int TR_BIT = 10;
  localparam int SA_HI  = 9;
  localparam int SA_LO  = 5;
  localparam int WC_HI  = 4;
  localparam logic [4:0] SA_MODE_LO = 5'h00;
  localparam logic [4:0] SA_MODE_HI = 5'h1F;
  localparam logic [5:0] WORDS_MAX  = 6'h20;

  typedef enum logic [2:0] {
    ST_CLEAR = 3'b001,
    ST_IDLE  = 3'b010,
    ST_FETCH = 3'b100
  } lk_state_t;

  typedef struct packed {
    logic        broadcast;
    logic [15:0] word;
  } cmd_t;

  typedef struct packed {
    logic       respond;
    logic       msgError;
    logic [5:0] dataWords;
  } verdict_t;

  function automatic logic isMode(cmd_t c);
    return (c.word[SA_HI:SA_LO] == SA_MODE_LO) ||
           (c.word[SA_HI:SA_LO] == SA_MODE_HI);
  endfunction

  // word index within the table
  function automatic logic [7:0] tableIndex(cmd_t c);
    return {~c.broadcast, c.word[TR_BIT], c.word[SA_HI:SA_LO], c.word[WC_HI]};
  endfunction

  function automatic logic isUndefinedMode(cmd_t c);
    logic [4:0] mc;
    mc = c.word[4:0];
    if (!isMode(c))
      return 1'b0;
    if (!c.word[TR_BIT])
      return (mc < 5'h11) || (mc == 5'h12) || (mc == 5'h13);
    return (mc == 5'h11) || (mc == 5'h14) || (mc == 5'h15);
  endfunction

  function automatic logic isBcastTxSub(cmd_t c);
    return c.broadcast && c.word[TR_BIT] && !isMode(c);
  endfunction

  function automatic logic [5:0] inFormWords(cmd_t c);
    if (isMode(c))
      return {5'h00, c.word[WC_HI]};
    if (c.word[4:0] == 5'h00)
      return WORDS_MAX;
    return {1'b0, c.word[4:0]};
  endfunction

endpackage

// >>> cmd_illegal_table.sv
// 256 x 16 legality table, one write port and two registered read ports
`timescale 1ns/10ps
module cmd_illegal_table (
  input  wire logic        sys_clk,
  input  wire logic        wrEn,
  input  wire logic [7:0]  wrAddr,
  input  wire logic [15:0] wrData,
  input  wire logic        rdEnA,
  input  wire logic [7:0]  rdAddrA,
  output logic      [15:0] rdDataA,
  input  wire logic [7:0]  rdAddrB,
  output logic      [15:0] rdDataB
);

  logic [15:0] mem [0:rt_illegal_pkg::TABLE_WORDS-1];
  logic [15:0] nxt_rdDataA;
  logic [15:0] nxt_rdDataB;
  logic [15:0] rdDataA_ff;
  logic [15:0] rdDataB_ff;

  // reads return the word held before a same-cycle write
  always_comb begin
    nxt_rdDataA = rdEnA ? mem[rdAddrA] : rdDataA_ff;
    nxt_rdDataB = mem[rdAddrB];
  end

  always_ff @(posedge sys_clk) begin
    rdDataA_ff <= nxt_rdDataA;
    rdDataB_ff <= nxt_rdDataB;
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  assign rdDataA = rdDataA_ff;
  assign rdDataB = rdDataB_ff;

endmodule

// >>> rt_bus_ctrl_model.sv
// bus controller model issuing command words to the checker
`timescale 1ns/10ps
module rt_bus_ctrl_model (
  input  wire logic                     sys_clk,
  output logic                          cmdValid,
  output rt_illegal_pkg::cmd_t          cmdIn,
  input  wire logic                     verdictValid,
  input  wire rt_illegal_pkg::verdict_t verdict
);
  initial begin
    cmdValid = 1'b0;
    cmdIn    = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one command, then up to four cycles for its verdict
  task automatic issue(input logic bc, input logic [15:0] w,
                       output logic got, output logic [7:0] v);
    @(posedge sys_clk);
    cmdValid <= 1'b1;
    cmdIn    <= {bc, w};
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    // idle lines carry no stale command
    cmdIn    <= ~{bc, w};
    got = 1'b0;
    v   = 8'h00;
    repeat (4) begin
      @(posedge sys_clk);
      #1;
      if (verdictValid === 1'b1 && !got) begin
        got = 1'b1;
        v   = verdict;
      end
    end
  endtask
endmodule

// >>> tb_rt_command_illegalization.sv
// self-checking bench for the command legality checker
`timescale 1ns/10ps
module tb_rt_command_illegalization;
  logic                     sys_clk;
  logic                     reset_n;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [11:0]              paddr;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic                     cmdValid;
  rt_illegal_pkg::cmd_t     cmdIn;
  logic                     cmdBusy;
  logic                     verdictValid;
  rt_illegal_pkg::verdict_t verdict;
  logic                     hostReady;
  logic [15:0]              tab [256];
  logic                     umc;
  logic [31:0]              rd;
  logic                     err;
  logic                     got;
  logic [7:0]               v;
  int                       n_mismatch;
  int                       num_checks;

  rt_command_illegalization u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmdValid(cmdValid),
    .cmdIn(cmdIn), .cmdBusy(cmdBusy), .verdictValid(verdictValid),
    .verdict(verdict), .hostReady(hostReady)
  );

  rt_bus_ctrl_model u_bc (
    .sys_clk(sys_clk), .cmdValid(cmdValid), .cmdIn(cmdIn),
    .verdictValid(verdictValid), .verdict(verdict)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] exp, input logic [31:0] gotv);
    num_checks++;
    if (gotv !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, gotv);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 1000);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 1000) n_mismatch++;
  endtask

  task automatic wrTab(input logic [7:0] idx, input logic [15:0] val);
    apb(1'b1, {2'b10, idx, 2'b00}, {16'h0000, val});
    tab[idx] = val;
  endtask

  // reference verdict: {respond, msgError, dataWords}
  function automatic logic [7:0] expV(input logic bc, input logic [15:0] w);
    int tr, sa, wc, md, ud, idx;
    tr = w[10];
    sa = w[9:5];
    wc = w[4:0];
    md = (sa == 0 || sa == 31);
    ud = tr ? (wc == 17 || wc == 20 || wc == 21)
            : (wc < 17 || wc == 18 || wc == 19);
    if (bc && tr && !md) return 8'h00;
    if (umc && md && ud) return 8'h00;
    idx = (bc ? 0 : 128) + tr * 64 + sa * 2 + wc / 16;
    if (tab[idx][wc % 16]) return 8'hC0;
    return 8'(128 + (md ? wc / 16 : (wc == 0 ? 32 : wc)));
  endfunction

  task automatic cmd(input logic bc, input logic [15:0] w);
    logic [7:0] e;
    u_bc.issue(bc, w, got, v);
    e = expV(bc, w);
    chk(32'h1, {31'h0, got});
    chk({24'h0, e}, {24'h0, v});
  endtask

  task automatic rnd(input logic mode);
    logic [31:0] r;
    logic [15:0] w;
    r = $urandom;
    w = r[15:0];
    if (mode) w[9:5] = {5{r[20]}};
    cmd(r[16], w);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    stop_test;
  end

  initial begin
    void'($urandom(68923));
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    reset_n = 1'b0;
    umc = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    for (int i = 0; i < 256; i++) tab[i] = 16'h0000;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    chk(32'h2, {30'h0, cmdBusy, hostReady});
    // first access stalls until the table clear ends
    apb(1'b0, 12'hB08, 32'h0);
    chk(32'h0, rd);
    chk(32'h1, {30'h0, cmdBusy, hostReady});
    apb(1'b0, 12'h004, 32'h0);
    chk(32'h1, {31'h0, rd[0]});
    apb(1'b0, 12'h400, 32'h0);
    chk(32'h1, {31'h0, err});
    apb(1'b1, 12'h004, 32'h0000_000F);
    chk(32'h1, {31'h0, err});
    u_bc.issue(1'b0, 16'h0421, got, v);
    chk(32'h0, {31'h0, got});
    apb(1'b1, 12'h000, 32'h0000_0001);
    repeat (40) rnd(1'b0);
    cmd(1'b1, 16'h0421);
    wrTab(8'hC2, 16'hFF0F);
    wrTab(8'hC3, 16'hFFFF);
    apb(1'b0, 12'hB08, 32'h0);
    chk(32'h0000_FF0F, rd);
    for (int c = 0; c < 32; c++) begin
      cmd(1'b0, 16'h0420 | 16'(c));
    end
    // last one: count 31, illegal, table index 0xC3
    apb(1'b0, 12'h004, 32'h0);
    chk(32'h0000_C30D, rd);
    apb(1'b1, 12'h000, 32'h0000_0000);
    for (int i = 0; i < 256; i++) begin
      // subaddress 31 words copy the subaddress 0 words
      wrTab(8'(i), ((i >> 1) & 31) == 31 ? tab[i & 8'hC1]
                                         : 16'($urandom));
    end
    apb(1'b1, 12'h000, 32'h0000_0001);
    repeat (300) rnd(1'b0);
    repeat (60) rnd(1'b1);
    umc = 1'b1;
    apb(1'b1, 12'h000, 32'h0000_0003);
    repeat (80) rnd(1'b1);
    stop_test;
  end
endmodule
